/* src/jbs_pkg.sv */
// Constants and types for the boundary-scan test port
// Notes on behaviour
// - There is no test-reset pin; the controller enters its reset state whenever the block is reset at power-up.
// - Sample/preload, external test, bypass, identification and high-impedance are the only instructions.
// - Every input pin and every one of the up to 68 I/O pins has its own scan cell.
// - All scan cells form one serial chain from the data input pin to the data output pin.
// - A cell has up to three capture stages and up to two update stages, and update stages drive pins only after update.
// - Pin cells and macrocell cells are two different kinds of cell that share the one chain.
// - Capture stages sample live signals on capture, shift on shift, and load the update stages on update.
// - The controller derives every capture, shift and update control from the test clock and mode-select pins.
// - The test port exists only while its configuration option is on, covering scan testing.
// - With the option off, the four test-port pins work as ordinary user I/O pins.
// - Pull-ups on the mode-select and data-input pins are optional and chosen by configuration.
package jbs_pkg;
  localparam int NUM_IO = 68;
  localparam int NUM_IN = 4;
  localparam int NUM_MC = 64;
  localparam int IO_STAGES = 3;
  localparam int CHAIN_LEN = IO_STAGES * NUM_IO + NUM_IN + NUM_MC;
  localparam int IN_BASE = IO_STAGES * NUM_IO;
  localparam int MC_BASE = IN_BASE + NUM_IN;
  localparam int IO_DIN_POS = 0;
  localparam int IO_DOUT_POS = 1;
  localparam int IO_OE_POS = 2;
  localparam int PIN_TCK = 0;
  localparam int PIN_TMS = 1;
  localparam int PIN_TDI = 2;
  localparam int PIN_TDO = 3;
  localparam int IR_W = 4;
  localparam logic [IR_W-1:0] OP_EXTEST = 4'h0;
  localparam logic [IR_W-1:0] OP_SAMPLE = 4'h1;
  localparam logic [IR_W-1:0] OP_IDCODE = 4'h2;
  localparam logic [IR_W-1:0] OP_HIGHZ = 4'h3;
  localparam logic [IR_W-1:0] OP_BYPASS = 4'hf;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
  localparam logic [IR_W-1:0] IR_RESET = OP_IDCODE;
  // Identification value is arbitrary
  localparam logic [31:0] ID_VALUE = 32'h0000_0a01;
  typedef enum logic [3:0] {
    JBS_RESET, JBS_IDLE, JBS_SEL_DR, JBS_CAP_DR, JBS_SHIFT_DR, JBS_EXIT1_DR, JBS_PAUSE_DR, JBS_EXIT2_DR,
    JBS_UPD_DR, JBS_SEL_IR, JBS_CAP_IR, JBS_SHIFT_IR, JBS_EXIT1_IR, JBS_PAUSE_IR, JBS_EXIT2_IR, JBS_UPD_IR
  } jbs_state_t;
endpackage : jbs_pkg

/* src/jbs_port.sv */
// Boundary-scan test access port with the chain of pin and macrocell scan cells
`timescale 1ns/1ps
`default_nettype none
module jbs_port
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Configuration options
  input wire logic port_enable,
  input wire logic tms_pullup_opt,
  input wire logic tdi_pullup_opt,
  output logic tms_pullup,
  output logic tdi_pullup,
  // Test-port pins (tck, tms, tdi, tdo)
  input wire logic [3:0] tpin_in,
  output logic [3:0] tpin_out,
  output logic [3:0] tpin_oe_n,
  // User logic behind the test-port pins
  input wire logic [3:0] tuser_out,
  input wire logic [3:0] tuser_oe,
  output logic [3:0] tuser_in,
  // Dedicated input pins
  input wire logic [jbs_pkg::NUM_IN-1:0] in_pin,
  // I/O pins
  input wire logic [jbs_pkg::NUM_IO-1:0] io_in,
  output logic [jbs_pkg::NUM_IO-1:0] io_out,
  output logic [jbs_pkg::NUM_IO-1:0] io_oe_n,
  // Core logic side of the I/O pins and macrocells
  input wire logic [jbs_pkg::NUM_IO-1:0] core_out,
  input wire logic [jbs_pkg::NUM_IO-1:0] core_oe,
  input wire logic [jbs_pkg::NUM_MC-1:0] mc_state
);
  import jbs_pkg::*;

  typedef struct packed {
    logic [3:0] tp_s1;
    logic [3:0] tp_s2;
    logic tck_d;
    logic [NUM_IO-1:0] io_s1;
    logic [NUM_IO-1:0] io_s2;
    logic [NUM_IN-1:0] in_s1;
    logic [NUM_IN-1:0] in_s2;
    jbs_state_t state;
    logic [IR_W-1:0] ir_sr;
    logic [IR_W-1:0] ir;
    logic [CHAIN_LEN-1:0] chain;
    logic [NUM_IO-1:0] upd_out;
    logic [NUM_IO-1:0] upd_oe;
    logic [31:0] id_sr;
    logic byp;
    logic tdo;
    logic tdo_en;
  } jbs_regs_t;

  jbs_regs_t r;
  jbs_regs_t next_r;
  logic tck_rise;
  logic tck_fall;
  logic tms;
  logic tdi;
  logic sel_chain;
  logic sel_id;
  logic extest;
  logic highz;

  // Sixteen-state controller
  function automatic jbs_state_t jbs_next_state(input jbs_state_t s, input logic m);
    jbs_state_t ns;
    ns = s;
    case (s)
      JBS_RESET: ns = m ? JBS_RESET : JBS_IDLE;
      JBS_IDLE: ns = m ? JBS_SEL_DR : JBS_IDLE;
      JBS_SEL_DR: ns = m ? JBS_SEL_IR : JBS_CAP_DR;
      JBS_CAP_DR: ns = m ? JBS_EXIT1_DR : JBS_SHIFT_DR;
      JBS_SHIFT_DR: ns = m ? JBS_EXIT1_DR : JBS_SHIFT_DR;
      JBS_EXIT1_DR: ns = m ? JBS_UPD_DR : JBS_PAUSE_DR;
      JBS_PAUSE_DR: ns = m ? JBS_EXIT2_DR : JBS_PAUSE_DR;
      JBS_EXIT2_DR: ns = m ? JBS_UPD_DR : JBS_SHIFT_DR;
      JBS_UPD_DR: ns = m ? JBS_SEL_DR : JBS_IDLE;
      JBS_SEL_IR: ns = m ? JBS_RESET : JBS_CAP_IR;
      JBS_CAP_IR: ns = m ? JBS_EXIT1_IR : JBS_SHIFT_IR;
      JBS_SHIFT_IR: ns = m ? JBS_EXIT1_IR : JBS_SHIFT_IR;
      JBS_EXIT1_IR: ns = m ? JBS_UPD_IR : JBS_PAUSE_IR;
      JBS_PAUSE_IR: ns = m ? JBS_EXIT2_IR : JBS_PAUSE_IR;
      JBS_EXIT2_IR: ns = m ? JBS_UPD_IR : JBS_SHIFT_IR;
      JBS_UPD_IR: ns = m ? JBS_SEL_DR : JBS_IDLE;
      default: ns = JBS_RESET;
    endcase
    return ns;
  endfunction : jbs_next_state

  // Edges of the sampled test clock
  assign tck_rise = port_enable & r.tp_s2[PIN_TCK] & ~r.tck_d;
  assign tck_fall = port_enable & ~r.tp_s2[PIN_TCK] & r.tck_d;
  assign tms = r.tp_s2[PIN_TMS];
  assign tdi = r.tp_s2[PIN_TDI];

  // Instruction decode; unknown codes fall to bypass
  assign extest = (r.ir == OP_EXTEST);
  assign highz = (r.ir == OP_HIGHZ);
  assign sel_chain = extest | (r.ir == OP_SAMPLE);
  assign sel_id = (r.ir == OP_IDCODE);

  always_comb
  begin
    next_r = r;
    next_r.tp_s1 = tpin_in;
    next_r.tp_s2 = r.tp_s1;
    next_r.tck_d = r.tp_s2[PIN_TCK];
    next_r.io_s1 = io_in;
    next_r.io_s2 = r.io_s1;
    next_r.in_s1 = in_pin;
    next_r.in_s2 = r.in_s1;
    if (tck_rise)
    begin
      case (r.state)
        JBS_CAP_DR:
        begin
          if (sel_chain)
          begin
            // Pin cells capture pin level, output data and enable
            for (int i = 0; i < NUM_IO; i++)
            begin
              next_r.chain[IO_STAGES*i+IO_DIN_POS] = r.io_s2[i];
              next_r.chain[IO_STAGES*i+IO_DOUT_POS] = core_out[i];
              next_r.chain[IO_STAGES*i+IO_OE_POS] = core_oe[i];
            end
            // Input pin cells
            for (int i = 0; i < NUM_IN; i++)
            begin
              next_r.chain[IN_BASE+i] = r.in_s2[i];
            end
            // Macrocell cells, one capture stage each
            for (int i = 0; i < NUM_MC; i++)
            begin
              next_r.chain[MC_BASE+i] = mc_state[i];
            end
          end
          else if (sel_id)
          begin
            next_r.id_sr = ID_VALUE;
          end
          else
          begin
            next_r.byp = 1'b0;
          end
        end
        JBS_SHIFT_DR:
        begin
          if (sel_chain)
          begin
            next_r.chain = {tdi, r.chain[CHAIN_LEN-1:1]};
          end
          else if (sel_id)
          begin
            next_r.id_sr = {tdi, r.id_sr[31:1]};
          end
          else
          begin
            next_r.byp = tdi;
          end
        end
        JBS_CAP_IR:
        begin
          next_r.ir_sr = IR_CAPTURE;
        end
        JBS_SHIFT_IR:
        begin
          next_r.ir_sr = {tdi, r.ir_sr[IR_W-1:1]};
        end
        default:
        begin
          next_r.ir_sr = r.ir_sr;
        end
      endcase
      next_r.state = jbs_next_state(r.state, tms);
    end
    if (tck_fall)
    begin
      case (r.state)
        JBS_SHIFT_DR:
        begin
          next_r.tdo = sel_chain ? r.chain[0] : (sel_id ? r.id_sr[0] : r.byp);
          next_r.tdo_en = 1'b1;
        end
        JBS_SHIFT_IR:
        begin
          next_r.tdo = r.ir_sr[0];
          next_r.tdo_en = 1'b1;
        end
        JBS_UPD_DR:
        begin
          next_r.tdo_en = 1'b0;
          if (sel_chain)
          begin
            for (int i = 0; i < NUM_IO; i++)
            begin
              next_r.upd_out[i] = r.chain[IO_STAGES*i+IO_DOUT_POS];
              next_r.upd_oe[i] = r.chain[IO_STAGES*i+IO_OE_POS];
            end
          end
        end
        JBS_UPD_IR:
        begin
          next_r.tdo_en = 1'b0;
          next_r.ir = r.ir_sr;
        end
        JBS_RESET:
        begin
          next_r.tdo_en = 1'b0;
          next_r.ir = IR_RESET;
        end
        default:
        begin
          next_r.tdo_en = 1'b0;
        end
      endcase
    end
    if (!port_enable)
    begin
      next_r.state = JBS_RESET;
      next_r.ir = IR_RESET;
      next_r.tdo_en = 1'b0;
    end
    if (!rstn)
    begin
      next_r = '0;
      next_r.state = JBS_RESET;
      next_r.ir = IR_RESET;
      next_r.ir_sr = IR_CAPTURE;
    end
  end

  always_ff @(posedge clk)
  begin
    r <= next_r;
  end

  // Pull-ups only while the port is in use
  assign tms_pullup = port_enable & tms_pullup_opt;
  assign tdi_pullup = port_enable & tdi_pullup_opt;

  // Test-port pins: test signals or user I/O
  always_comb
  begin
    if (port_enable)
    begin
      tpin_out = {r.tdo, 3'h0};
      tpin_oe_n = {~r.tdo_en, 3'h7};
      tuser_in = 4'h0;
    end
    else
    begin
      tpin_out = tuser_out;
      tpin_oe_n = ~tuser_oe;
      tuser_in = r.tp_s2;
    end
  end

  // I/O pins under test instructions
  always_comb
  begin
    if (highz)
    begin
      io_out = core_out;
      io_oe_n = {NUM_IO{1'b1}};
    end
    else if (extest)
    begin
      io_out = r.upd_out;
      io_oe_n = ~r.upd_oe;
    end
    else
    begin
      io_out = core_out;
      io_oe_n = ~core_oe;
    end
  end
endmodule : jbs_port
`default_nettype wire

/* tb/jbs_port_asserts.sv */
// Assertions on the pins of the boundary-scan test port
`timescale 1ns/1ps
`default_nettype none
module jbs_port_asserts
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Options and test-port pins
  input wire logic port_enable,
  input wire logic tms_pullup_opt,
  input wire logic tdi_pullup_opt,
  input wire logic tms_pullup,
  input wire logic tdi_pullup,
  input wire logic [3:0] tpin_in,
  input wire logic [3:0] tpin_out,
  input wire logic [3:0] tpin_oe_n,
  input wire logic [3:0] tuser_out,
  input wire logic [3:0] tuser_oe,
  input wire logic [3:0] tuser_in,
  // I/O pins and core side
  input wire logic [jbs_pkg::NUM_IO-1:0] io_out,
  input wire logic [jbs_pkg::NUM_IO-1:0] io_oe_n,
  input wire logic [jbs_pkg::NUM_IO-1:0] core_out,
  input wire logic [jbs_pkg::NUM_IO-1:0] core_oe
);
  import jbs_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_pull;
    $stable(port_enable) |-> {tms_pullup, tdi_pullup} == ({tms_pullup_opt, tdi_pullup_opt} & {2{port_enable}});
  endproperty
  a_pull: assert property (p_pull) else $error("pull-up select");
  property p_user;
    (!port_enable)[*2] |-> tpin_out == tuser_out && tpin_oe_n == ~tuser_oe;
  endproperty
  a_user: assert property (p_user) else $error("user pin drive");
  property p_core;
    (!port_enable)[*3] |-> io_out == core_out && io_oe_n == ~core_oe;
  endproperty
  a_core: assert property (p_core) else $error("core pin drive");
  property p_rst;
    $rose(rstn) && port_enable && $past(port_enable) |-> tpin_oe_n[3];
  endproperty
  a_rst: assert property (p_rst) else $error("data output driven after reset");
  property p_ctl;
    port_enable[*3] |-> tpin_oe_n[2:0] == 3'h7 && tuser_in == 4'h0;
  endproperty
  a_ctl: assert property (p_ctl) else $error("control pins");
  property p_tdo;
    port_enable[*3] ##0 $changed(tpin_out[3]) |-> !$past(tpin_in[0], 2);
  endproperty
  a_tdo: assert property (p_tdo) else $error("data output moved with clock high");
  property p_tdo_en;
    port_enable[*3] ##0 $fell(tpin_oe_n[3]) |-> !$past(tpin_in[0], 2);
  endproperty
  a_tdo_en: assert property (p_tdo_en) else $error("data output enabled with clock high");
  property p_upd;
    port_enable[*3] ##0 ($changed(io_out) || $changed(io_oe_n)) && $stable(core_out) && $stable(core_oe)
      |-> !$past(tpin_in[0], 2);
  endproperty
  a_upd: assert property (p_upd) else $error("pin update with clock high");
  c_tdo: cover property (port_enable ##1 $changed(tpin_out[3]));
  c_highz: cover property (port_enable && &io_oe_n && !(&core_oe));
  c_off: cover property ((!port_enable)[*3]);
endmodule : jbs_port_asserts
bind jbs_port jbs_port_asserts chk_u (.*);
`default_nettype wire

/* tb/jbs_tester.sv */
// Behavioural test-port master on the link pins
`timescale 1ns/1ps
`default_nettype none
module jbs_tester
(
  // Bench clock and link pins
  input wire logic clk,
  output var logic tck,
  output var logic tms,
  output var logic tdi,
  input wire logic tdo
);
  // Test clock stands low outside frames
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  task bit_io(input logic m, input logic t, output logic q);
    tms <= m;
    tdi <= t;
    repeat (4) @(posedge clk);
    q = tdo;
    tck <= 1'b1;
    repeat (4) @(posedge clk);
    tck <= 1'b0;
  endtask : bit_io
  task reset_idle;
    logic q;
    repeat (5) bit_io(1'b1, 1'b0, q);
    bit_io(1'b0, 1'b0, q);
  endtask : reset_idle
  task scan(input logic ir, input int n, input logic [jbs_pkg::CHAIN_LEN-1:0] din,
            output logic [jbs_pkg::CHAIN_LEN-1:0] dout);
    logic q;
    dout = '0;
    bit_io(1'b1, 1'b0, q);
    if (ir)
      bit_io(1'b1, 1'b0, q);
    bit_io(1'b0, 1'b0, q);
    bit_io(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++)
    begin
      bit_io(i == n - 1, din[i], q);
      dout[i] = q;
    end
    bit_io(1'b1, 1'b0, q);
    bit_io(1'b0, 1'b0, q);
  endtask : scan
endmodule : jbs_tester
`default_nettype wire

/* tb/tb_top.sv */
// Testbench for the boundary-scan test port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import jbs_pkg::*;
  typedef logic [CHAIN_LEN-1:0] jbs_vec_t;
  logic clk, rstn, port_enable, tms_pullup_opt, tdi_pullup_opt, tms_pullup, tdi_pullup, tck, tms, tdi, q;
  logic [3:0] tpin_out, tpin_oe_n, tuser_out, tuser_oe, tuser_in;
  logic [NUM_IN-1:0] in_pin;
  logic [NUM_IO-1:0] io_in, io_out, io_oe_n, core_out, core_oe;
  logic [NUM_MC-1:0] mc_state;
  wire logic [3:0] tpin_in = (~tpin_oe_n & tpin_out) | (tpin_oe_n & {~tpin_out[3], tdi, tms, tck});
  int miscompares = 0;
  int tests_run = 0;
  jbs_vec_t d, e;
  jbs_vec_t pat = {4{68'h9_3c5a_f0e1_2d4b_7869}};
  jbs_port dut_u
  (
    .clk(clk),
    .rstn(rstn),
    .port_enable(port_enable),
    .tms_pullup_opt(tms_pullup_opt),
    .tdi_pullup_opt(tdi_pullup_opt),
    .tms_pullup(tms_pullup),
    .tdi_pullup(tdi_pullup),
    .tpin_in(tpin_in),
    .tpin_out(tpin_out),
    .tpin_oe_n(tpin_oe_n),
    .tuser_out(tuser_out),
    .tuser_oe(tuser_oe),
    .tuser_in(tuser_in),
    .in_pin(in_pin),
    .io_in(io_in),
    .io_out(io_out),
    .io_oe_n(io_oe_n),
    .core_out(core_out),
    .core_oe(core_oe),
    .mc_state(mc_state)
  );
  jbs_tester tst_u (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tpin_in[3]));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task final_report;
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report
  task chk(input jbs_vec_t seen, input jbs_vec_t exp, input string what);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask : chk
  task t_idcode;
    tst_u.scan(1'b0, 32, '0, d);
    chk(d, jbs_vec_t'(ID_VALUE), "identification");
  endtask : t_idcode
  task t_bypass;
    logic [IR_W-1:0] ops [2];
    ops = '{OP_BYPASS, 4'h7};
    foreach (ops[k])
    begin
      tst_u.scan(1'b1, IR_W, jbs_vec_t'(ops[k]), d);
      chk(d, jbs_vec_t'(IR_CAPTURE), "instruction capture");
      tst_u.scan(1'b0, 8, jbs_vec_t'(8'ha5), d);
      chk(d, jbs_vec_t'(8'h4a), "bypass stage");
    end
  endtask : t_bypass
  task t_chain;
    @(posedge clk);
    io_in <= 68'h5_a3c9_0f12_3456_789a;
    core_out <= 68'hc_0ffe_e123_4567_89ab;
    core_oe <= 68'h3_f00f_1234_abcd_5a5a;
    in_pin <= 4'h6;
    mc_state <= 64'h0123_4567_89ab_cdef;
    tst_u.scan(1'b1, IR_W, jbs_vec_t'(OP_SAMPLE), d);
    tst_u.scan(1'b0, CHAIN_LEN, pat, d);
    for (int i = 0; i < NUM_IO; i++)
      e[3*i +: 3] = {core_oe[i], core_out[i], io_in[i]};
    e[IN_BASE +: NUM_IN] = in_pin;
    e[MC_BASE +: NUM_MC] = mc_state;
    chk(d, e, "sampled chain");
    chk(jbs_vec_t'({io_oe_n, io_out}), jbs_vec_t'({~core_oe, core_out}), "pins during preload");
    tst_u.scan(1'b1, IR_W, jbs_vec_t'(OP_EXTEST), d);
    e = '0;
    for (int i = 0; i < NUM_IO; i++)
      {e[NUM_IO+i], e[i]} = {~pat[3*i+2], pat[3*i+1]};
    chk(jbs_vec_t'({io_oe_n, io_out}), e, "external test drive");
    tst_u.scan(1'b1, IR_W, jbs_vec_t'(OP_HIGHZ), d);
    chk(jbs_vec_t'(io_oe_n), jbs_vec_t'({NUM_IO{1'b1}}), "high impedance");
  endtask : t_chain
  task t_off;
    @(posedge clk);
    port_enable <= 1'b0;
    tuser_out <= 4'h5;
    tuser_oe <= 4'h5;
    tst_u.scan(1'b1, IR_W, jbs_vec_t'(OP_HIGHZ), d);
    chk(jbs_vec_t'({tpin_out, tpin_oe_n}), jbs_vec_t'(8'h5a), "user pin drive");
    chk(jbs_vec_t'(tuser_in), jbs_vec_t'(4'hd), "user pin input");
    chk(jbs_vec_t'({tms_pullup, tdi_pullup, io_oe_n}), jbs_vec_t'({2'h0, ~core_oe}), "port off");
    @(posedge clk);
    port_enable <= 1'b1;
    tms_pullup_opt <= 1'b0;
    tdi_pullup_opt <= 1'b1;
    @(posedge clk);
    chk(jbs_vec_t'({tms_pullup, tdi_pullup}), jbs_vec_t'(2'h1), "pull-up select");
  endtask : t_off
  initial
  begin
    rstn = 1'b0;
    port_enable = 1'b1;
    tms_pullup_opt = 1'b1;
    tdi_pullup_opt = 1'b0;
    tuser_out = 4'h0;
    tuser_oe = 4'h0;
    in_pin = '0;
    io_in = '0;
    core_out = '0;
    core_oe = '0;
    mc_state = '0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    chk(jbs_vec_t'({tms_pullup, tdi_pullup, tpin_oe_n[3]}), jbs_vec_t'(3'h5), "idle after reset");
    tst_u.bit_io(1'b0, 1'b0, q);
    t_idcode();
    t_bypass();
    t_chain();
    t_off();
    tst_u.reset_idle();
    t_idcode();
    final_report();
  end
  initial
  begin
    #1_000_000;
    miscompares++;
    final_report();
  end
endmodule : tb_top
`default_nettype wire
